// [common/field_flag_map.svh]
// register offsets, field positions, reset values and trip levels of the field flag block
`ifndef FIELD_FLAG_MAP_SVH
`define FIELD_FLAG_MAP_SVH

// register addresses on the serial link
`define CONFIG_ADDR 5'h06
`define STATUS_ADDR 5'h1b

// threshold configuration layout
`define LOW_CODE_MSB 7
`define LOW_CODE_LSB 5
`define HIGH_CODE_MSB 4
`define HIGH_CODE_LSB 2
`define CONFIG_RESET 8'h1c

// status layout
`define STATUS_HIGH_BIT 7
`define STATUS_LOW_BIT 6

// rising trip levels in mT for codes 0 to 7
`define RISE_LEVEL_0 8'h1a
`define RISE_LEVEL_1 8'h29
`define RISE_LEVEL_2 8'h38
`define RISE_LEVEL_3 8'h46
`define RISE_LEVEL_4 8'h54
`define RISE_LEVEL_5 8'h62
`define RISE_LEVEL_6 8'h70
`define RISE_LEVEL_7 8'h7e
// fixed hysteresis band in mT
`define FLAG_HYSTERESIS 8'h06

// serial frame shape
`define FRAME_LAST_BIT 4'hf

`endif

// [common/field_flag_pkg.sv]
// types shared by the field flag block
package field_flag_pkg;

  // serial command codes
  typedef enum logic [2:0] {
    CMD_READ = 3'b010,
    CMD_WRITE = 3'b100
  } cmd_e;

  // serial link pins as seen by the device
  typedef struct packed {
    logic sclk;
    logic csN;
    logic mosi;
  } spi_in_s;

  // one decoded frame
  typedef struct packed {
    logic [2:0] cmd;
    logic [4:0] addr;
    logic [7:0] value;
  } frame_s;

endpackage : field_flag_pkg

// [src/field_threshold_button_flags.sv]
// field threshold comparators with hysteresis and their serial register port
`timescale 1ns/1ns
`include "field_flag_map.svh"

// Contract
// R1 - the high-field flag goes to one when the field rises above the high threshold's level.
// R2 - the low-field flag goes to one when the field drops below the low threshold's level.
// R3 - both thresholds are three-bit codes held in one 8-bit register at address 6.
// R4 - codes 0 to 7 select rising levels 26 to 126 mT and falling levels 20 to 120 mT.
// R5 - a low code larger than the high code is accepted unchanged.
// R6 - the status register at address 27 shows the high flag in bit 7, the low flag in bit 6.
// R7 - each flag is also driven continuously on its own output pin.
// R8 - the host fetches the flags with a 16-bit frame of command 010, address 11011, zero value.
// R9 - a read command is answered in the frame that follows it.
// R10 - the low code sits in bits 7 to 5 and the high code in bits 4 to 2 of the config register.
module field_threshold_button_flags (
  input wire logic clk_sys,
  input wire logic reset,
  input wire field_flag_pkg::spi_in_s spiIn,
  input wire logic [7:0] fieldStrength,
  output logic miso,
  output logic fieldHighFlag,
  output logic fieldLowFlag
);
  import field_flag_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // level tables

  // rising trip level for a code
  function automatic logic [7:0] riseLevel(input logic [2:0] code);
    logic [7:0] level;
    level = `RISE_LEVEL_0;
    unique case (code)
      3'h0: level = `RISE_LEVEL_0;
      3'h1: level = `RISE_LEVEL_1;
      3'h2: level = `RISE_LEVEL_2;
      3'h3: level = `RISE_LEVEL_3;
      3'h4: level = `RISE_LEVEL_4;
      3'h5: level = `RISE_LEVEL_5;
      3'h6: level = `RISE_LEVEL_6;
      3'h7: level = `RISE_LEVEL_7;
    endcase
    return level;
  endfunction : riseLevel

  // falling level sits one hysteresis band below
  function automatic logic [7:0] fallLevel(input logic [2:0] code);
    return riseLevel(code) - `FLAG_HYSTERESIS; // [R4]
  endfunction : fallLevel

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic sclkMeta, sclkSync, sclkLast;
  logic csMeta, csSync, csLast;
  logic mosiMeta, mosiSync;

  // two flops per pin, plus a history flop on sclk and on csN for edge finding
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkLast <= 1'b0;
      csMeta <= 1'b1;
      csSync <= 1'b1;
      csLast <= 1'b1;
      mosiMeta <= 1'b0;
      mosiSync <= 1'b0;
    end else begin
      sclkMeta <= spiIn.sclk;
      sclkSync <= sclkMeta;
      sclkLast <= sclkSync;
      csMeta <= spiIn.csN;
      csSync <= csMeta;
      csLast <= csSync;
      mosiMeta <= spiIn.mosi;
      mosiSync <= mosiMeta;
    end
  end

  logic sclkRise, sclkFall, csFall;
  assign sclkRise = sclkSync & ~sclkLast;
  assign sclkFall = ~sclkSync & sclkLast;
  assign csFall = csLast & ~csSync;

  ////////////////////////////////////////////////////////////////////////////////
  // serial frame engine and registers

  logic [3:0] bitCount, next_bitCount;
  logic [14:0] shiftIn, next_shiftIn;
  logic [15:0] shiftOut, next_shiftOut;
  logic [7:0] replyByte, next_replyByte;
  logic [7:0] thresholdConfig, next_thresholdConfig;
  logic next_miso;
  logic frameDone, isRead, isWrite;
  frame_s frameWord;
  logic [2:0] highCode, lowCode;

  // code fields of the config register
  assign lowCode = thresholdConfig[`LOW_CODE_MSB:`LOW_CODE_LSB]; // [R10]
  assign highCode = thresholdConfig[`HIGH_CODE_MSB:`HIGH_CODE_LSB]; // [R10]

  // frame completes on the sixteenth rising clock edge
  assign frameDone = ~csSync & sclkRise & (bitCount == `FRAME_LAST_BIT);
  assign frameWord = {shiftIn, mosiSync};
  assign isRead = frameDone & (frameWord.cmd == CMD_READ); // [R8]
  assign isWrite = frameDone & (frameWord.cmd == CMD_WRITE);

  // register read mux, spare status bits read zero
  function automatic logic [7:0] regRead(input logic [4:0] addr, input logic [7:0] cfg,
                                         input logic hi, input logic lo);
    logic [7:0] data;
    data = 8'h00;
    if (addr == `CONFIG_ADDR) begin
      data = cfg;
    end else if (addr == `STATUS_ADDR) begin
      data[`STATUS_HIGH_BIT] = hi; // [R6]
      data[`STATUS_LOW_BIT] = lo; // [R6]
    end
    return data;
  endfunction : regRead

  // next state of shifters, reply and config
  always_comb begin
    next_bitCount = bitCount;
    next_shiftIn = shiftIn;
    next_shiftOut = shiftOut;
    next_miso = miso;
    next_replyByte = replyByte;
    next_thresholdConfig = thresholdConfig;
    if (csSync) begin
      next_bitCount = 4'h0;
      next_miso = 1'b0;
    end else if (csFall) begin
      // answer of the previous frame goes out first
      next_bitCount = 4'h0;
      next_shiftOut = {replyByte, 8'h00}; // [R9]
      next_miso = replyByte[7]; // [R9]
    end else begin
      if (sclkRise) begin
        next_shiftIn = frameWord[14:0];
        next_bitCount = bitCount + 4'h1;
      end
      if (sclkFall) begin
        next_shiftOut = {shiftOut[14:0], 1'b0};
        next_miso = shiftOut[14];
      end
      if (frameDone) begin
        // reply is held for the next frame, not this one
        next_replyByte = isRead ? regRead(frameWord.addr, thresholdConfig, fieldHighFlag,
                                          fieldLowFlag) : 8'h00; // [R9]
        // any code pair is kept as written
        if (isWrite && frameWord.addr == `CONFIG_ADDR) begin
          next_thresholdConfig = frameWord.value; // [R3] [R5]
        end
      end
    end
  end

  // register the frame engine
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bitCount <= 4'h0;
      shiftIn <= 15'h0000;
      shiftOut <= 16'h0000;
      miso <= 1'b0;
      replyByte <= 8'h00;
      thresholdConfig <= `CONFIG_RESET;
    end else begin
      bitCount <= next_bitCount;
      shiftIn <= next_shiftIn;
      shiftOut <= next_shiftOut;
      miso <= next_miso;
      replyByte <= next_replyByte;
      thresholdConfig <= next_thresholdConfig;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // field comparators with hysteresis

  logic next_fieldHigh, next_fieldLow;

  // set past one level, clear past the other, hold in between
  always_comb begin
    next_fieldHigh = fieldHighFlag;
    next_fieldLow = fieldLowFlag;
    if (fieldStrength > riseLevel(highCode)) begin
      next_fieldHigh = 1'b1; // [R1]
    end else if (fieldStrength < fallLevel(highCode)) begin
      next_fieldHigh = 1'b0; // [R4]
    end
    if (fieldStrength < fallLevel(lowCode)) begin
      next_fieldLow = 1'b1; // [R2]
    end else if (fieldStrength > riseLevel(lowCode)) begin
      next_fieldLow = 1'b0; // [R4]
    end
  end

  // flag flops drive the pins directly
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fieldHighFlag <= 1'b0; // [R7]
      fieldLowFlag <= 1'b0; // [R7]
    end else begin
      fieldHighFlag <= next_fieldHigh;
      fieldLowFlag <= next_fieldLow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence readDone_q;
    isRead;
  endsequence

  // start of the frame that carries a pending reply
  sequence nextFrameStart_q;
    csFall;
  endsequence

  high_flag_set_a: assert property ( // [R1]
    fieldStrength > riseLevel(highCode) |=> fieldHighFlag)
    else $error("high flag not set above rising level");

  low_flag_set_a: assert property ( // [R2]
    fieldStrength < fallLevel(lowCode) |=> fieldLowFlag)
    else $error("low flag not set below falling level");

  config_write_a: assert property ( // [R3]
    isWrite && frameWord.addr == `CONFIG_ADDR
      |=> thresholdConfig == $past(frameWord.value) ##1 $stable(thresholdConfig))
    else $error("config write not stored");

  hyst_hold_a: assert property ( // [R4]
    fieldHighFlag && fieldStrength >= fallLevel(highCode) |=> fieldHighFlag)
    else $error("high flag dropped inside hysteresis band");

  config_stable_a: assert property ( // [R5]
    !(isWrite && frameWord.addr == `CONFIG_ADDR) |=> $stable(thresholdConfig))
    else $error("config changed without a write");

  status_reply_a: assert property ( // [R6]
    isRead && frameWord.addr == `STATUS_ADDR
      |=> replyByte == {$past(fieldHighFlag), $past(fieldLowFlag), 6'h00})
    else $error("status reply bits wrong");

  pin_cause_a: assert property ( // [R7]
    $changed(fieldLowFlag) |-> $past(fieldStrength) < fallLevel($past(lowCode))
                            || $past(fieldStrength) > riseLevel($past(lowCode)))
    else $error("low pin moved without a field cause");

  reply_next_a: assert property ( // [R9]
    nextFrameStart_q |=> miso == $past(replyByte[7]))
    else $error("reply not first bit of next frame");

endmodule : field_threshold_button_flags

// [tb/spi_host_model.sv]
// serial host model that sends whole frames to the field flag block
`timescale 1ns/1ns
module spi_host_model (
  input wire logic clk_sys,
  input wire logic miso,
  output field_flag_pkg::spi_in_s spiIn
);
  import field_flag_pkg::*;
  logic sclk = 1'b0;
  logic csN = 1'b1;
  logic mosi = 1'b0;
  // pins packed in struct order
  assign spiIn = {sclk, csN, mosi};
  //////////////////////////////////////////////////////////////////////////////
  // one 16-bit mode 0 frame, 10 clocks per half period, clock still outside
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    csN <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi <= tx[i]; // msb first
      repeat (10) @(posedge clk_sys);
      sclk <= 1'b1;
      rx[i] = miso;
      repeat (10) @(posedge clk_sys);
      sclk <= 1'b0;
    end
    repeat (10) @(posedge clk_sys);
    csN <= 1'b1;
    mosi <= ~tx[0]; // released line shows no stale bit
    repeat (10) @(posedge clk_sys);
  endtask : frame
endmodule : spi_host_model

// [tb/field_threshold_button_flags_tb_top.sv]
// self-checking bench for the field threshold flags and their register port
`timescale 1ns/1ns
`include "field_flag_map.svh"
module field_threshold_button_flags_tb_top;
  import field_flag_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] fieldStrength = 8'h40;
  logic miso;
  logic fieldHighFlag;
  logic fieldLowFlag;
  spi_in_s spiIn;
  logic [15:0] rx;
  logic [7:0] cfg = `CONFIG_RESET;
  int n_errors = 0;
  int comparisons = 0;
  // rows: config byte, field in mT, expected high and low flag
  logic [17:0] rows [12] = '{
    {8'h1c, 8'h7f, 2'b10}, {8'h1c, 8'h79, 2'b10}, {8'h1c, 8'h77, 2'b00},
    {8'h1c, 8'h7e, 2'b00}, {8'h1c, 8'h13, 2'b01}, {8'h1c, 8'h1a, 2'b01},
    {8'h1c, 8'h1b, 2'b00}, {8'he0, 8'h1b, 2'b11}, {8'he0, 8'h7f, 2'b10},
    {8'he0, 8'h13, 2'b01}, {8'h6c, 8'h47, 2'b10}, {8'h6c, 8'h3f, 2'b01}};
  //////////////////////////////////////////////////////////////////////////////
  // clock and instances
  always #2 clk_sys = ~clk_sys;
  field_threshold_button_flags dut (
    .clk_sys(clk_sys),
    .reset(reset),
    .spiIn(spiIn),
    .fieldStrength(fieldStrength),
    .miso(miso),
    .fieldHighFlag(fieldHighFlag),
    .fieldLowFlag(fieldLowFlag)
  );
  spi_host_model host (
    .clk_sys(clk_sys),
    .miso(miso),
    .spiIn(spiIn)
  );
  //////////////////////////////////////////////////////////////////////////////
  // comparison and closing report
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : check
  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    check({fieldHighFlag, fieldLowFlag, miso}, 16'h0000); // reset levels
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    foreach (rows[r]) begin
      if (rows[r][17:10] !== cfg) begin
        cfg = rows[r][17:10];
        host.frame({CMD_WRITE, `CONFIG_ADDR, cfg}, rx);
      end
      fieldStrength <= rows[r][9:2];
      repeat (3) @(posedge clk_sys);
      check({fieldHighFlag, fieldLowFlag}, rows[r][1:0]);
    end
    // read frames: reply lags one frame, flags in bits 7 and 6
    host.frame({CMD_READ, `STATUS_ADDR, 8'h00}, rx);
    check(rx, 16'h0000);
    fieldStrength <= 8'h7f;
    host.frame({CMD_READ, `STATUS_ADDR, 8'h00}, rx);
    check(rx, 16'h4000);
    host.frame({CMD_READ, `CONFIG_ADDR, 8'h00}, rx);
    check(rx, 16'h8000);
    host.frame({CMD_READ, 5'h1f, 8'h00}, rx);
    check(rx, 16'h6c00);
    host.frame({CMD_READ, `STATUS_ADDR, 8'h00}, rx);
    check(rx, 16'h0000); // unmapped address reads zero
    host.frame(16'h0000, rx);
    check(rx, 16'h8000);
    // second reset in mid-run restores the config
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check({fieldHighFlag, fieldLowFlag}, 16'h0002);
    host.frame({CMD_READ, `CONFIG_ADDR, 8'h00}, rx);
    check(rx, 16'h0000);
    host.frame(16'h0000, rx);
    check(rx, 16'h1c00);
    complete_run();
  end
  // watchdog against a hang
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    complete_run();
  end
endmodule : field_threshold_button_flags_tb_top
